// ===== logic/perf_evt_pkg.sv
// shared constants for the core event qualification and counting block
package perf_evt_pkg;

    // configuration register field layout
    localparam int CFG_W      = 64;
    localparam int EVT_LO_LSB = 0;
    localparam int EVT_LO_W   = 8;
    localparam int UNIT_LSB   = 8;
    localparam int UNIT_W     = 8;
    localparam int APP_BIT    = 16;
    localparam int KERN_BIT   = 17;
    localparam int EDGE_BIT   = 18;
    localparam int INT_BIT    = 20;
    localparam int ON_BIT     = 22;
    localparam int FLIP_BIT   = 23;
    localparam int THR_LSB    = 24;
    localparam int THR_W      = 8;
    localparam int EVT_HI_LSB = 32;
    localparam int EVT_HI_W   = 4;
    localparam int GUEST_BIT  = 40;
    localparam int HOST_BIT   = 41;
    localparam int CODE_W     = EVT_HI_W + EVT_LO_W;

    // writable bits of the configuration register, the rest read zero
    localparam logic [63:0] CFG_WRITABLE = 64'h0000_030f_ffd7_ffff;
    localparam logic [63:0] CFG_RESET    = 64'h0000_0000_0000_0000;

    // register addresses
    localparam logic [31:0] CFG_BASE     = 32'h0000_0c00;
    localparam logic [31:0] CTR_BASE     = 32'h0000_0c10;
    localparam logic [31:0] HWCFG_ADDR   = 32'h0000_0c20;
    localparam logic [31:0] RETIRED_ADDR = 32'hc000_00e9;

    // hardware configuration bit that runs the retired counter
    localparam int RETIRED_EN_BIT = 30;

    // per-cycle count saturation and the privileged level
    localparam int          SAT_LIMIT   = 32;
    localparam logic [1:0]  PRIV_KERNEL = 2'h0;

    // answer kinds of the register port
    typedef enum logic [1:0] {
        ANS_NONE,
        ANS_DONE,
        ANS_FAULT
    } answer_type;

endpackage

// ===== logic/event_filter_stage.sv
// per-counter qualification filter producing a registered increment
module event_filter_stage
    import perf_evt_pkg::*;
#(
    parameter int CNT_W   = 6,
    parameter int MAX_THR = 31
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // configuration and core state
    input  wire logic [CFG_W-1:0] cfg,
    input  wire logic [1:0]       cur_priv,
    input  wire logic             in_guest,
    input  wire logic             virt_on,
    input  wire logic             supported,
    // event source and result
    input  wire logic [CNT_W-1:0] evt_count,
    output logic      [CNT_W-1:0] incr
);

    // elaboration check of the parameters
    if (CNT_W < 6 || CNT_W > 8 || MAX_THR < 1 || MAX_THR > 255) begin : g_chk
        $error("event_filter_stage: unsupported parameter values");
    end

    localparam logic [CNT_W-1:0] SAT_VAL = CNT_W'(SAT_LIMIT);

    logic [THR_W-1:0] thr;
    logic             thr_zero;
    logic             priv_ok;
    logic             dom_ok;
    logic             qualify;
    logic             cmp;
    logic             cond;
    logic             qcond;
    logic             prev;
    logic [CNT_W-1:0] raw;
    logic [CNT_W-1:0] next_incr;

    // field decode and qualification
    assign thr      = cfg[THR_LSB +: THR_W];
    assign thr_zero = (thr == 8'h00);
    assign priv_ok  = (cur_priv == PRIV_KERNEL) ? cfg[KERN_BIT]
                                                : cfg[APP_BIT];
    assign dom_ok   = (!cfg[GUEST_BIT] && !cfg[HOST_BIT]) ||
                      !virt_on ||
                      (in_guest ? cfg[GUEST_BIT] : cfg[HOST_BIT]);
    assign qualify  = cfg[ON_BIT] && priv_ok && dom_ok && supported;

    // threshold compare and per-cycle value
    assign cmp   = (8'(evt_count) >= thr);
    assign cond  = thr_zero ? (evt_count != '0)
                            : (cmp ^ cfg[FLIP_BIT]);
    assign qcond = qualify && cond;
    assign raw   = thr_zero ? ((evt_count >= SAT_VAL) ? SAT_VAL
                                                      : evt_count)
                            : CNT_W'(cond);

    // choose between edge counting and level counting
    always_comb begin
        next_incr = '0;
        if (cfg[EDGE_BIT]) begin
            next_incr = CNT_W'(qcond && !prev);
        end else if (qualify) begin
            next_incr = raw;
        end
    end

    // previous qualified condition for edge detection
    always_ff @(posedge clk) begin
        if (rst) begin
            prev <= 1'b0;
        end else begin
            prev <= qcond;
        end
    end

    // registered increment ahead of the counter update
    always_ff @(posedge clk) begin
        if (rst) begin
            incr <= '0;
        end else begin
            incr <= next_incr;
        end
    end

    chk_sat_limit: assert property (@(posedge clk) disable iff (rst)
        incr <= SAT_VAL)
        else $error("increment above saturation limit");

    chk_gate_blocks: assert property (@(posedge clk) disable iff (rst)
        !qualify |=> incr == '0)
        else $error("increment without qualification");

    chk_edge_once: assert property (@(posedge clk) disable iff (rst)
        (cfg[EDGE_BIT] && qcond) ##1 (cfg[EDGE_BIT] && qcond)
        |=> incr == '0)
        else $error("edge mode counted a held condition");

    chk_thr_step: assert property (@(posedge clk) disable iff (rst)
        (qualify && !thr_zero && !cfg[EDGE_BIT])
        |=> incr == CNT_W'($past(cmp) ^ $past(cfg[FLIP_BIT])))
        else $error("threshold increment wrong");

endmodule

// ===== logic/perf_event_select_filter.sv
// core performance counters with event qualification and config registers
//
// How it works
// - each counter owns one 64-bit configuration register
// - event code is upper four bits above lower eight, twelve total
// - both domain bits clear: count in guest and host alike
// - with virtualization on, domain bits restrict counting to guest/host
// - zero threshold adds per-cycle event count, saturating at 32
// - nonzero threshold, no flip: add one when count reaches threshold
// - nonzero threshold, flip set: add one when count below threshold
// - largest threshold is a parameter; larger writes clamp to it
// - counting-on bit enables the pair; clear holds counter value
// - overflow raises interrupt only when interrupt enable is set
// - edge mode counts only rising transitions of the condition
// - kernel and application bits gate counting by privilege level
// - unit qualifier goes to event sources to pick subevents
// - one event code may be restricted to some counters
// - config access only at level zero, else fault, no change
// - dedicated retired counter, enabled by bit 30, capability reported
// - counter width is a parameter up to 64, software writable
// - config write takes effect on completion of that write
module perf_event_select_filter
    import perf_evt_pkg::*;
#(
    parameter int          NUM_CTR      = 4,
    parameter int          CTR_W        = 48,
    parameter int          CNT_W        = 6,
    parameter int          RET_W        = 3,
    parameter int          MAX_THR      = 31,
    parameter logic [11:0] LIMITED_CODE = 12'hfff,
    parameter logic [15:0] LIMITED_SET  = 16'h0001
) (
    // clock and reset
    input  wire logic                      CLK_SYS,
    input  wire logic                      RST,
    // register access port
    input  wire logic [31:0]               MSR_ADDR,
    input  wire logic                      MSR_RD,
    input  wire logic                      MSR_WR,
    input  wire logic [63:0]               MSR_WDATA,
    output logic      [63:0]               MSR_RDATA,
    output logic                           MSR_ACK,
    output logic                           MSR_GP_FAULT,
    // core state
    input  wire logic [1:0]                CUR_PRIV_LEVEL,
    input  wire logic                      IN_GUEST,
    input  wire logic                      VIRTUALIZATION_ON,
    // event sources
    input  wire logic [NUM_CTR*CNT_W-1:0]  EVENT_COUNT,
    input  wire logic [RET_W-1:0]          INSTR_RETIRED,
    output logic      [NUM_CTR*CODE_W-1:0] EVENT_CODE,
    output logic      [NUM_CTR*UNIT_W-1:0] UNIT_QUAL,
    // overflow and capability
    output logic      [NUM_CTR-1:0]        OVF_IRQ,
    output logic      [NUM_CTR-1:0]        OVF_PULSE,
    output logic                           RETIRED_CAP
);

    // elaboration check of the parameters
    if (NUM_CTR < 1 || NUM_CTR > 16 || CTR_W < 1 || CTR_W > 64 ||
        RET_W < 1 || RET_W > 8) begin : g_chk
        $error("perf_event_select_filter: unsupported parameter values");
    end

    localparam int IDX_W = (NUM_CTR > 1) ? $clog2(NUM_CTR) : 1;
    localparam logic [THR_W-1:0] THR_MAX = THR_W'(MAX_THR);

    // address window hit
    function automatic logic in_window(input logic [31:0] addr,
                                       input logic [31:0] base);
        logic [31:0] off;
        off = addr - base;
        return off < 32'(NUM_CTR);
    endfunction

    // index inside an address window
    function automatic logic [IDX_W-1:0] win_index(input logic [31:0] addr,
                                                   input logic [31:0] base);
        logic [31:0] off;
        off = addr - base;
        return off[IDX_W-1:0];
    endfunction

    // event code support per counter
    function automatic logic code_supported(input int idx,
                                            input logic [CODE_W-1:0] code);
        return (code != LIMITED_CODE) || LIMITED_SET[idx];
    endfunction

    logic [CFG_W-1:0] cfg [NUM_CTR];
    logic [CTR_W-1:0] tally [NUM_CTR];
    logic [CNT_W-1:0] incr [NUM_CTR];
    logic [63:0]      retired_count;
    logic             retired_on;
    logic             hit_cfg;
    logic             hit_ctr;
    logic             hit_ret;
    logic             hit_hw;
    logic             req;
    logic             priv_ok;
    logic             legal;
    logic             wr_ok;
    logic [IDX_W-1:0] idx_cfg;
    logic [IDX_W-1:0] idx_ctr;
    logic [63:0]      wr_cfg;
    logic [63:0]      next_rdata;
    answer_type       next_answer;

    // request decode and privilege check
    assign hit_cfg = in_window(MSR_ADDR, CFG_BASE);
    assign hit_ctr = in_window(MSR_ADDR, CTR_BASE);
    assign hit_ret = (MSR_ADDR == RETIRED_ADDR);
    assign hit_hw  = (MSR_ADDR == HWCFG_ADDR);
    assign idx_cfg = win_index(MSR_ADDR, CFG_BASE);
    assign idx_ctr = win_index(MSR_ADDR, CTR_BASE);
    assign req     = MSR_RD || MSR_WR;
    assign priv_ok = (CUR_PRIV_LEVEL == PRIV_KERNEL);
    assign legal   = req && priv_ok &&
                     (hit_cfg || hit_ctr || hit_ret || hit_hw);
    assign wr_ok   = legal && MSR_WR;

    // write value with reserved bits cleared and threshold clamped
    always_comb begin
        wr_cfg = MSR_WDATA & CFG_WRITABLE;
        if (wr_cfg[THR_LSB +: THR_W] > THR_MAX) begin
            wr_cfg[THR_LSB +: THR_W] = THR_MAX;
        end
    end

    // answer kind for the current request
    always_comb begin
        next_answer = ANS_NONE;
        if (legal) begin
            next_answer = ANS_DONE;
        end else if (req) begin
            next_answer = ANS_FAULT;
        end
    end

    // read data selection
    always_comb begin
        next_rdata = 64'h0000_0000_0000_0000;
        if (legal && !MSR_WR) begin
            if (hit_cfg) begin
                next_rdata = cfg[idx_cfg];
            end else if (hit_ctr) begin
                next_rdata = 64'(tally[idx_ctr]);
            end else if (hit_ret) begin
                next_rdata = retired_count;
            end else if (hit_hw) begin
                next_rdata[RETIRED_EN_BIT] = retired_on;
            end
        end
    end

    // registered answer of the register port
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            MSR_RDATA    <= 64'h0000_0000_0000_0000;
            MSR_ACK      <= 1'b0;
            MSR_GP_FAULT <= 1'b0;
        end else begin
            MSR_RDATA    <= next_rdata;
            MSR_ACK      <= (next_answer == ANS_DONE);
            MSR_GP_FAULT <= (next_answer == ANS_FAULT);
        end
    end

    // per-counter configuration, filter and counter
    for (genvar i = 0; i < NUM_CTR; i++) begin : g_ctr
        logic [CTR_W:0]    sum;
        logic [CODE_W-1:0] code;

        assign code = {cfg[i][EVT_HI_LSB +: EVT_HI_W],
                       cfg[i][EVT_LO_LSB +: EVT_LO_W]};
        assign sum  = {1'b0, tally[i]} + (CTR_W+1)'(incr[i]);
        assign EVENT_CODE[i*CODE_W +: CODE_W] = code;
        assign UNIT_QUAL[i*UNIT_W +: UNIT_W]  =
            cfg[i][UNIT_LSB +: UNIT_W];

        // configuration register of this counter
        always_ff @(posedge CLK_SYS) begin
            if (RST) begin
                cfg[i] <= CFG_RESET;
            end else if (wr_ok && hit_cfg && idx_cfg == IDX_W'(i)) begin
                cfg[i] <= wr_cfg;
            end
        end

        event_filter_stage #(
            .CNT_W   (CNT_W),
            .MAX_THR (MAX_THR)
        ) u_filter (
            .clk       (CLK_SYS),
            .rst       (RST),
            .cfg       (cfg[i]),
            .cur_priv  (CUR_PRIV_LEVEL),
            .in_guest  (IN_GUEST),
            .virt_on   (VIRTUALIZATION_ON),
            .supported (code_supported(i, code)),
            .evt_count (EVENT_COUNT[i*CNT_W +: CNT_W]),
            .incr      (incr[i])
        );

        // counter with software load, wrap and overflow indication
        always_ff @(posedge CLK_SYS) begin
            if (RST) begin
                tally[i]     <= '0;
                OVF_PULSE[i] <= 1'b0;
                OVF_IRQ[i]   <= 1'b0;
            end else if (wr_ok && hit_ctr && idx_ctr == IDX_W'(i)) begin
                tally[i]     <= MSR_WDATA[CTR_W-1:0];
                OVF_PULSE[i] <= 1'b0;
                OVF_IRQ[i]   <= 1'b0;
            end else begin
                tally[i]     <= sum[CTR_W-1:0];
                OVF_PULSE[i] <= sum[CTR_W];
                OVF_IRQ[i]   <= sum[CTR_W] && cfg[i][INT_BIT];
            end
        end

        chk_ctr_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
            (!cfg[i][ON_BIT] && !(wr_ok && hit_ctr)) ##1
            !(wr_ok && hit_ctr) |=> $stable(tally[i]))
            else $error("disabled counter changed");

        chk_irq_gate: assert property (@(posedge CLK_SYS) disable iff (RST)
            OVF_IRQ[i] |-> OVF_PULSE[i] && $past(cfg[i][INT_BIT]))
            else $error("interrupt without enable or overflow");

        chk_wrap_zero: assert property (@(posedge CLK_SYS) disable iff (RST)
            OVF_PULSE[i] |-> tally[i] < CTR_W'($past(incr[i])))
            else $error("overflow pulse without wrap");
    end

    // hardware configuration bit for the retired counter
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            retired_on <= 1'b0;
        end else if (wr_ok && hit_hw) begin
            retired_on <= MSR_WDATA[RETIRED_EN_BIT];
        end
    end

    // dedicated retired instruction counter
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            retired_count <= 64'h0000_0000_0000_0000;
        end else if (wr_ok && hit_ret) begin
            retired_count <= MSR_WDATA;
        end else if (retired_on) begin
            retired_count <= retired_count + 64'(INSTR_RETIRED);
        end
    end

    // capability flag for the retired counter
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            RETIRED_CAP <= 1'b0;
        end else begin
            RETIRED_CAP <= 1'b1;
        end
    end

    chk_fault_answer: assert property (@(posedge CLK_SYS) disable iff (RST)
        req && !priv_ok |=> MSR_GP_FAULT && !MSR_ACK &&
        MSR_RDATA == 64'h0000_0000_0000_0000)
        else $error("unprivileged access not faulted");

    chk_fault_keeps: assert property (@(posedge CLK_SYS) disable iff (RST)
        MSR_WR && !priv_ok && hit_cfg |=> $stable(cfg[0]))
        else $error("faulted write changed configuration");

    chk_legal_ack: assert property (@(posedge CLK_SYS) disable iff (RST)
        legal |=> MSR_ACK && !MSR_GP_FAULT)
        else $error("legal access not acknowledged");

    chk_idle_quiet: assert property (@(posedge CLK_SYS) disable iff (RST)
        !req |=> !MSR_ACK && !MSR_GP_FAULT &&
        MSR_RDATA == 64'h0000_0000_0000_0000)
        else $error("answer without a request");

    chk_ret_count: assert property (@(posedge CLK_SYS) disable iff (RST)
        retired_on && !(wr_ok && hit_ret) |=>
        retired_count == $past(retired_count) +
                         64'($past(INSTR_RETIRED)))
        else $error("retired counter did not advance");

endmodule

// ===== sim/event_source_model.sv
// model of the core event sources feeding per-cycle event counts
module event_source_model #(
    parameter int NUM_CTR = 4,
    parameter int CNT_W   = 6
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // burst control from the bench
    input  wire logic                     active,
    input  wire logic                     tog,
    input  wire logic [CNT_W-1:0]         val,
    input  wire logic [CNT_W-1:0]         idle,
    // per-cycle event counts, one lane per counter
    output logic      [NUM_CTR*CNT_W-1:0] evt_count
);
    timeunit 1ns;
    timeprecision 1ps;

    logic phase;

    // counts change just after each edge; toggle mode blanks every
    // second cycle so the condition rises once per pair of cycles
    always_ff @(posedge clk) begin
        if (rst) begin
            evt_count <= '0;
            phase     <= 1'h0;
        end else if (active) begin
            evt_count <= (tog && phase) ? '0 : {NUM_CTR{val}};
            phase     <= ~phase;
        end else begin
            evt_count <= {NUM_CTR{idle}};
            phase     <= 1'h0;
        end
    end
endmodule

// ===== sim/tb_perf_event_select_filter.sv
// self-checking bench for the core event qualification block
module tb_perf_event_select_filter;
    import perf_evt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [63:0] B   = 64'h0000_0000_0043_00c1;
    localparam logic [63:0] TH6 = 64'h0000_0000_0600_0000;
    localparam logic [63:0] FL  = 64'h0000_0000_0080_0000;
    localparam logic [63:0] ED  = 64'h0000_0000_0004_0000;
    localparam logic [63:0] GU  = 64'h0000_0100_0000_0000;
    localparam logic [63:0] HO  = 64'h0000_0200_0000_0000;

    typedef struct {
        logic [63:0] cfg;
        logic [3:0]  md;
        logic [5:0]  val;
        logic [5:0]  idle;
        logic        tog;
        logic [7:0]  exp;
    } case_type;

    logic        CLK_SYS, RST, MSR_RD, MSR_WR, MSR_ACK, MSR_GP_FAULT;
    logic        IN_GUEST, VIRTUALIZATION_ON, RETIRED_CAP;
    logic [31:0] MSR_ADDR;
    logic [63:0] MSR_WDATA, MSR_RDATA;
    logic [1:0]  CUR_PRIV_LEVEL;
    logic [23:0] EVENT_COUNT;
    logic [2:0]  INSTR_RETIRED;
    logic [47:0] EVENT_CODE;
    logic [31:0] UNIT_QUAL;
    logic [3:0]  OVF_IRQ, OVF_PULSE;
    logic        ev_active, ev_tog;
    logic [5:0]  ev_val, ev_idle;
    int          mismatches, cmp_count, cycles, ovf_n, irq_n;
    case_type    tbl[20];

    // design under test with its default sizes
    perf_event_select_filter #(
        .NUM_CTR(4), .CTR_W(48), .CNT_W(6), .RET_W(3)
    ) u_dut (
        .CLK_SYS(CLK_SYS), .RST(RST), .MSR_ADDR(MSR_ADDR),
        .MSR_RD(MSR_RD), .MSR_WR(MSR_WR), .MSR_WDATA(MSR_WDATA),
        .MSR_RDATA(MSR_RDATA), .MSR_ACK(MSR_ACK),
        .MSR_GP_FAULT(MSR_GP_FAULT), .CUR_PRIV_LEVEL(CUR_PRIV_LEVEL),
        .IN_GUEST(IN_GUEST), .VIRTUALIZATION_ON(VIRTUALIZATION_ON),
        .EVENT_COUNT(EVENT_COUNT), .INSTR_RETIRED(INSTR_RETIRED),
        .EVENT_CODE(EVENT_CODE), .UNIT_QUAL(UNIT_QUAL),
        .OVF_IRQ(OVF_IRQ), .OVF_PULSE(OVF_PULSE), .RETIRED_CAP(RETIRED_CAP)
    );

    // event sources on the far side
    event_source_model u_src (
        .clk(CLK_SYS), .rst(RST), .active(ev_active), .tog(ev_tog),
        .val(ev_val), .idle(ev_idle), .evt_count(EVENT_COUNT)
    );

    // clock at 100 MHz
    initial begin
        CLK_SYS = 1'h0;
        forever #5 CLK_SYS = ~CLK_SYS;
    end

    // overflow pulse counting on counter 0 and hang guard
    always @(posedge CLK_SYS) begin
        cycles++;
        if (OVF_PULSE[0] === 1'h1) ovf_n++;
        if (OVF_IRQ[0] === 1'h1) irq_n++;
        if (cycles == 5000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one register access; the answer stands in the cycle after taking
    task automatic acc(input logic w, input logic [31:0] a,
                       input logic [63:0] d, input logic f,
                       input logic [63:0] e);
        @(posedge CLK_SYS);
        MSR_ADDR  <= a;
        MSR_WR    <= w;
        MSR_RD    <= ~w;
        MSR_WDATA <= d;
        @(posedge CLK_SYS);
        MSR_WR <= 1'h0;
        MSR_RD <= 1'h0;
        #1;
        chk(MSR_GP_FAULT, f);
        chk(MSR_ACK, !f);
        chk(MSR_RDATA, w ? 64'h0 : e);
    endtask

    // four cycles of events under a given core state, then settle
    task automatic burst(input logic [5:0] v, input logic tg,
                         input logic [3:0] md);
        @(posedge CLK_SYS);
        ev_val            <= v;
        ev_tog            <= tg;
        ev_active         <= 1'h1;
        CUR_PRIV_LEVEL    <= md[3:2];
        IN_GUEST          <= md[1];
        VIRTUALIZATION_ON <= md[0];
        repeat (4) @(posedge CLK_SYS);
        ev_active <= 1'h0;
        repeat (3) @(posedge CLK_SYS);
        CUR_PRIV_LEVEL    <= 2'h0;
        IN_GUEST          <= 1'h0;
        VIRTUALIZATION_ON <= 1'h0;
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        {RST, MSR_RD, MSR_WR, IN_GUEST, VIRTUALIZATION_ON} = 5'h10;
        {MSR_ADDR, MSR_WDATA, CUR_PRIV_LEVEL, INSTR_RETIRED} = '0;
        {ev_active, ev_tog, ev_val, ev_idle} = '0;
        tbl = '{
            '{B, 4'h0, 6'h05, 6'h00, 1'h0, 8'h14},
            '{B, 4'h0, 6'h28, 6'h00, 1'h0, 8'h80},
            '{B|TH6, 4'h0, 6'h05, 6'h00, 1'h0, 8'h00},
            '{B|TH6, 4'h0, 6'h06, 6'h00, 1'h0, 8'h04},
            '{B|TH6|FL, 4'h0, 6'h05, 6'h0a, 1'h0, 8'h04},
            '{B|TH6|FL, 4'h0, 6'h06, 6'h0a, 1'h0, 8'h00},
            '{B|ED, 4'h0, 6'h03, 6'h00, 1'h1, 8'h02},
            '{64'h40_00c1, 4'h0, 6'h01, 6'h00, 1'h0, 8'h00},
            '{64'h41_00c1, 4'hc, 6'h01, 6'h00, 1'h0, 8'h04},
            '{64'h41_00c1, 4'h0, 6'h01, 6'h00, 1'h0, 8'h00},
            '{64'h42_00c1, 4'hc, 6'h01, 6'h00, 1'h0, 8'h00},
            '{B, 4'hc, 6'h01, 6'h00, 1'h0, 8'h04},
            '{B|GU, 4'h1, 6'h01, 6'h00, 1'h0, 8'h00},
            '{B|GU, 4'h3, 6'h01, 6'h00, 1'h0, 8'h04},
            '{B|HO, 4'h3, 6'h01, 6'h00, 1'h0, 8'h00},
            '{B|HO|GU, 4'h1, 6'h01, 6'h00, 1'h0, 8'h04},
            '{B|GU, 4'h0, 6'h01, 6'h00, 1'h0, 8'h04},
            '{B, 4'h3, 6'h01, 6'h00, 1'h0, 8'h04},
            '{64'h03_00c1, 4'h0, 6'h01, 6'h00, 1'h0, 8'h00},
            '{64'hf_0043_00ff, 4'h0, 6'h01, 6'h00, 1'h0, 8'h00}
        };
        repeat (4) @(posedge CLK_SYS);
        RST <= 1'h0;
        // reset contents, field mask, threshold clamp and outputs
        acc(1'h0, CFG_BASE, 64'h0, 1'h0, 64'h0);
        chk(RETIRED_CAP, 1'h1);
        acc(1'h1, CFG_BASE, '1, 1'h0, 64'h0);
        acc(1'h0, CFG_BASE, 64'h0, 1'h0, 64'h0000_030f_1fd7_ffff);
        acc(1'h1, CFG_BASE, 64'ha_0000_5b3c, 1'h0, 64'h0);
        chk(EVENT_CODE[11:0], 12'ha3c);
        chk(UNIT_QUAL[7:0], 8'h5b);
        // accesses above level zero and to an unmapped place
        @(posedge CLK_SYS) CUR_PRIV_LEVEL <= 2'h3;
        acc(1'h1, CFG_BASE, '1, 1'h1, 64'h0);
        acc(1'h0, CFG_BASE, 64'h0, 1'h1, 64'h0);
        @(posedge CLK_SYS) CUR_PRIV_LEVEL <= 2'h0;
        acc(1'h0, CFG_BASE, 64'h0, 1'h0, 64'ha_0000_5b3c);
        acc(1'h0, 32'h0000_0c30, 64'h0, 1'h1, 64'h0);
        // qualification modes on counter 1
        foreach (tbl[i]) begin
            @(posedge CLK_SYS) ev_idle <= tbl[i].idle;
            acc(1'h1, CFG_BASE + 32'h1, tbl[i].cfg, 1'h0, 64'h0);
            acc(1'h1, CTR_BASE + 32'h1, 64'h0, 1'h0, 64'h0);
            burst(tbl[i].val, tbl[i].tog, tbl[i].md);
            acc(1'h0, CTR_BASE + 32'h1, 64'h0, 1'h0, 64'(tbl[i].exp));
        end
        ev_idle <= 6'h00;
        // preload near all ones, wrap with and without interrupt enable
        acc(1'h1, CFG_BASE, 64'h53_0000, 1'h0, 64'h0);
        acc(1'h1, CTR_BASE, 64'hffff_ffff_ffff_fffe, 1'h0, 64'h0);
        acc(1'h0, CTR_BASE, 64'h0, 1'h0, 64'hffff_ffff_fffe);
        burst(6'h01, 1'h0, 4'h0);
        acc(1'h0, CTR_BASE, 64'h0, 1'h0, 64'h2);
        chk(ovf_n, 1);
        chk(irq_n, 1);
        acc(1'h1, CFG_BASE, 64'h43_0000, 1'h0, 64'h0);
        acc(1'h1, CTR_BASE, 64'hffff_ffff_fffe, 1'h0, 64'h0);
        burst(6'h01, 1'h0, 4'h0);
        chk(ovf_n, 2);
        chk(irq_n, 1);
        // retired counter runs only while its enable bit is set
        acc(1'h1, HWCFG_ADDR, '1, 1'h0, 64'h0);
        acc(1'h0, HWCFG_ADDR, 64'h0, 1'h0, 64'h4000_0000);
        acc(1'h1, RETIRED_ADDR, 64'h0, 1'h0, 64'h0);
        for (int k = 0; k < 2; k++) begin
            @(posedge CLK_SYS) INSTR_RETIRED <= 3'h3;
            repeat (5) @(posedge CLK_SYS);
            INSTR_RETIRED <= 3'h0;
            repeat (3) @(posedge CLK_SYS);
            acc(1'h0, RETIRED_ADDR, 64'h0, 1'h0, 64'hf);
            acc(1'h1, HWCFG_ADDR, 64'h0, 1'h0, 64'h0);
        end
        stop_test();
    end
endmodule
